// >>> tcg_cfg.svh
`ifndef TCG_CFG_SVH
`define TCG_CFG_SVH
// Register byte addresses on the APB
`define TCG_OFF_CTRL      12'h000
`define TCG_OFF_FAST_PRE  12'h004
`define TCG_OFF_SLOW_PRE  12'h008
`define TCG_OFF_AUX_PRE   12'h00C
`define TCG_OFF_STATUS    12'h010
// Control register bit positions
`define TCG_BIT_SLOW_SEL  0
`define TCG_BIT_FAST_SEL  1
`define TCG_BIT_PLL_PWD   2
`define TCG_BIT_AUX1_EN   3
`define TCG_BIT_AUX2_EN   4
// Control register reset value: main clock, PLL off, aux clocks on
`define TCG_CTRL_RESET    8'h1E
// Fast prescaler fields: divider in [3:0], multiplier mode in [5:4]
`define TCG_FPRE_DIV_LSB  0
`define TCG_FPRE_MODE_LSB 4
`define TCG_FPRE_RESET    8'h10
`define TCG_SPRE_RESET    8'hFF
`define TCG_APRE_RESET    8'h00
// Start-up counter presets
`define TCG_MAIN_PRESET   14'h3FFF
`define TCG_SLOW_PRESET   6'h3F
// PLL lock time in ns, converted to cycles at 10 ns
`define TCG_PLL_LOCK_NS   1000
`define TCG_CLK_NS        10
`define TCG_PLL_LOCK_CYC  (`TCG_PLL_LOCK_NS / `TCG_CLK_NS)
// Slow oscillator toggles seen before it counts as running
`define TCG_TOGGLE_NEED   4'h4
`endif

// >>> tcg_clock_gen.sv
`timescale 1ns/1ps
`include "tcg_cfg.svh"
module tcg_clock_gen #(
   parameter int MAIN_CNT_W = 14,
   parameter int SLOW_CNT_W = 6,
   parameter int PLL_LOCK   = `TCG_PLL_LOCK_CYC
) (
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Power management requests
   input  wire tcg_pkg::tcg_pm_req_t pm_req,
   // Oscillator inputs, one-cycle pulse per main cycle or per slow edge
   input  wire logic        main_osc_tick,
   input  wire logic        slow_osc_edge,
   // Oscillator controls and status
   output logic             high_freq_oscillator_en,
   output logic             slow_osc_en,
   output tcg_pkg::tcg_good_t good,
   // PLL control
   output logic             pll_power_down,
   output logic [1:0]       pll_mult,
   // Clock enables
   output tcg_pkg::tcg_ticks_t ticks,
   output logic             sys_from_pll,
   output logic             slow_from_osc
);
   logic [7:0] clock_reset_control;
   logic [7:0] fast_prescale_reg;
   logic [7:0] slow_pre;
   logic [7:0] aux_pre;
   logic [MAIN_CNT_W-1:0] main_cnt;
   logic [SLOW_CNT_W-1:0] slow_cnt;
   logic       main_half;
   logic [3:0] toggle_cnt;
   logic       slow_toggling;
   logic [15:0] lock_cnt;
   tcg_pkg::tcg_src_t src;
   logic       wr;
   logic       fast_source_select;
   logic       half_tick;
   logic       pre_tick;
   logic       aux1_tick;
   logic       aux2_tick;
   logic       sys_tick;

   assign wr      = psel && penable && pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // Main start-up timer, one count per two main oscillator ticks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_cnt  <= `TCG_MAIN_PRESET;
         main_half <= 1'b0;
      end else if (pm_req.stop_main) begin
         main_cnt  <= `TCG_MAIN_PRESET;
         main_half <= 1'b0;
      end else if (main_osc_tick && main_cnt != '0) begin
         // 16383 counts of two ticks each give 32,766 cycles
         main_half <= ~main_half;
         if (main_half)
            main_cnt <= main_cnt - 1'b1;
      end
   end
   assign high_freq_oscillator_en = !pm_req.stop_main;
   assign good.main_good = !pm_req.stop_main && main_cnt == '0;

   // Slow start-up timer, counted on oscillator edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_cnt <= `TCG_SLOW_PRESET;
      end else if (pm_req.stop_slow) begin
         slow_cnt <= `TCG_SLOW_PRESET;
      end else if (slow_osc_edge && slow_cnt != '0) begin
         slow_cnt <= slow_cnt - 1'b1;
      end
   end
   assign slow_osc_en    = !pm_req.stop_slow;
   assign good.slow_good = !pm_req.stop_slow && slow_cnt == '0;

   // Toggle detector on the slow oscillator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         toggle_cnt <= 4'h0;
      end else if (pm_req.stop_slow) begin
         toggle_cnt <= 4'h0;
      end else if (slow_osc_edge && toggle_cnt != `TCG_TOGGLE_NEED) begin
         toggle_cnt <= toggle_cnt + 4'h1;
      end
   end
   assign slow_toggling = toggle_cnt == `TCG_TOGGLE_NEED;

   // Control and prescaler registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_reset_control <= `TCG_CTRL_RESET;
         fast_prescale_reg   <= `TCG_FPRE_RESET;
         slow_pre            <= `TCG_SPRE_RESET;
         aux_pre             <= `TCG_APRE_RESET;
      end else if (wr) begin
         unique case (paddr)
            `TCG_OFF_CTRL: begin
               clock_reset_control <= pwdata[7:0];
               // Fast select bit is owned by the switching logic below
               clock_reset_control[`TCG_BIT_FAST_SEL] <= clock_reset_control[`TCG_BIT_FAST_SEL];
            end
            `TCG_OFF_FAST_PRE: fast_prescale_reg <= pwdata[7:0];
            `TCG_OFF_SLOW_PRE: slow_pre          <= pwdata[7:0];
            `TCG_OFF_AUX_PRE:  aux_pre           <= pwdata[7:0];
            default: ;
         endcase
      end
   end
   assign pll_power_down = clock_reset_control[`TCG_BIT_PLL_PWD];
   assign pll_mult       = fast_prescale_reg[`TCG_FPRE_MODE_LSB +: 2];

   // System source switch: main, waiting for lock, PLL
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src      <= tcg_pkg::TCG_SRC_MAIN;
         lock_cnt <= 16'h0000;
      end else begin
         unique case (src)
            tcg_pkg::TCG_SRC_MAIN: begin
               lock_cnt <= 16'h0000;
               // Clear request ignored while the PLL is powered down
               if (wr && paddr == `TCG_OFF_CTRL && !pwdata[`TCG_BIT_FAST_SEL] && !pll_power_down)
                  src <= tcg_pkg::TCG_SRC_LOCK;
            end
            tcg_pkg::TCG_SRC_LOCK: begin
               if (pll_power_down || (wr && paddr == `TCG_OFF_CTRL && pwdata[`TCG_BIT_FAST_SEL]))
                  src <= tcg_pkg::TCG_SRC_MAIN;
               else if (lock_cnt == 16'(PLL_LOCK - 1))
                  src <= tcg_pkg::TCG_SRC_PLL;
               else
                  lock_cnt <= lock_cnt + 16'h0001;
            end
            tcg_pkg::TCG_SRC_PLL: begin
               if (pll_power_down || (wr && paddr == `TCG_OFF_CTRL && pwdata[`TCG_BIT_FAST_SEL]))
                  src <= tcg_pkg::TCG_SRC_MAIN;
            end
            default: src <= tcg_pkg::TCG_SRC_MAIN;
         endcase
      end
   end
   assign fast_source_select = src != tcg_pkg::TCG_SRC_PLL;
   assign sys_from_pll       = !fast_source_select;

   // Slow clock source: oscillator only when selected and toggling
   assign slow_from_osc = clock_reset_control[`TCG_BIT_SLOW_SEL] && slow_toggling;

   // Fixed divide by two ahead of the slow prescaler
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         half_tick <= 1'b0;
      else
         half_tick <= ~half_tick;
   end

   // Slow prescaler, stopped when the oscillator drives the slow clock
   tcg_divider #(.W(8)) u_slow_div (
      .pclk    (pclk),
      .presetn (presetn),
      .in_en   (half_tick && !slow_from_osc),
      .ratio   (slow_pre),
      .tick    (pre_tick)
   );

   // System clock divider, ratio 1 to 16
   tcg_divider #(.W(4)) u_sys_div (
      .pclk    (pclk),
      .presetn (presetn),
      .in_en   (1'b1),
      .ratio   (fast_prescale_reg[`TCG_FPRE_DIV_LSB +: 4]),
      .tick    (sys_tick)
   );

   // Auxiliary clock dividers, free of the system divider
   tcg_divider #(.W(4)) u_aux1_div (
      .pclk    (pclk),
      .presetn (presetn),
      .in_en   (clock_reset_control[`TCG_BIT_AUX1_EN]),
      .ratio   (aux_pre[3:0]),
      .tick    (aux1_tick)
   );
   tcg_divider #(.W(4)) u_aux2_div (
      .pclk    (pclk),
      .presetn (presetn),
      .in_en   (clock_reset_control[`TCG_BIT_AUX2_EN]),
      .ratio   (aux_pre[7:4]),
      .tick    (aux2_tick)
   );

   // Clock enable bundle
   assign ticks.sys_en  = sys_tick;
   assign ticks.slow_en = slow_from_osc ? slow_osc_edge : pre_tick;
   assign ticks.aux1_en = aux1_tick;
   assign ticks.aux2_en = aux2_tick;

   // Read data, registered in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            `TCG_OFF_CTRL: begin
               prdata <= {24'h000000, clock_reset_control};
               prdata[`TCG_BIT_FAST_SEL] <= fast_source_select;
            end
            `TCG_OFF_FAST_PRE: prdata <= {24'h000000, fast_prescale_reg};
            `TCG_OFF_SLOW_PRE: prdata <= {24'h000000, slow_pre};
            `TCG_OFF_AUX_PRE:  prdata <= {24'h000000, aux_pre};
            `TCG_OFF_STATUS:   prdata <= {29'h00000000, slow_toggling, good.slow_good, good.main_good};
            default:           prdata <= 32'h00000000;
         endcase
      end
   end

   // Checks
   a_main_preset: assert property (@(posedge pclk) disable iff (!presetn)
      pm_req.stop_main |=> main_cnt == `TCG_MAIN_PRESET && !good.main_good)
      else $error("main counter not preset");
   a_main_good: assert property (@(posedge pclk) disable iff (!presetn)
      good.main_good |-> main_cnt == '0 && !pm_req.stop_main)
      else $error("main good early");
   a_main_step: assert property (@(posedge pclk) disable iff (!presetn)
      !pm_req.stop_main && main_osc_tick && main_half && main_cnt != '0 |=> main_cnt == $past(main_cnt) - 1'b1)
      else $error("main counter step wrong");
   a_main_hold: assert property (@(posedge pclk) disable iff (!presetn)
      main_cnt == '0 && !pm_req.stop_main |=> main_cnt == '0)
      else $error("main counter left zero");
   a_main_restart: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(pm_req.stop_main) |-> main_cnt == `TCG_MAIN_PRESET)
      else $error("main count not from preset");
   a_slow_preset: assert property (@(posedge pclk) disable iff (!presetn)
      pm_req.stop_slow |=> slow_cnt == `TCG_SLOW_PRESET)
      else $error("slow counter not preset");
   a_slow_step: assert property (@(posedge pclk) disable iff (!presetn)
      !pm_req.stop_slow && slow_osc_edge && slow_cnt != '0 |=> slow_cnt == $past(slow_cnt) - 1'b1)
      else $error("slow counter step wrong");
   a_slow_hold: assert property (@(posedge pclk) disable iff (!presetn)
      slow_cnt == '0 && !pm_req.stop_slow |=> slow_cnt == '0)
      else $error("slow counter left zero");
   a_slow_good: assert property (@(posedge pclk) disable iff (!presetn)
      good.slow_good |-> slow_cnt == '0 && !pm_req.stop_slow)
      else $error("slow good early");
   a_slow_source: assert property (@(posedge pclk) disable iff (!presetn)
      slow_from_osc |-> slow_toggling && clock_reset_control[`TCG_BIT_SLOW_SEL])
      else $error("slow source without toggling");
   a_slow_pre_off: assert property (@(posedge pclk) disable iff (!presetn)
      slow_from_osc |=> !pre_tick)
      else $error("prescaler runs on oscillator");
   a_pll_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      src == tcg_pkg::TCG_SRC_MAIN && pll_power_down |=> src == tcg_pkg::TCG_SRC_MAIN)
      else $error("PLL selected while off");
   a_pll_down: assert property (@(posedge pclk) disable iff (!presetn)
      pll_power_down |=> !sys_from_pll)
      else $error("PLL in use while powered down");
   a_pll_back: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == `TCG_OFF_CTRL && pwdata[`TCG_BIT_FAST_SEL] |=> !sys_from_pll)
      else $error("no return to main");
   a_lock_first: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(sys_from_pll) |-> $past(src) == tcg_pkg::TCG_SRC_LOCK)
      else $error("PLL used before lock");
   a_lock_count: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(sys_from_pll) |-> $past(lock_cnt) == 16'(PLL_LOCK - 1))
      else $error("PLL used before lock time");
   c_main_good: cover property (@(posedge pclk) disable iff (!presetn) $rose(good.main_good));
   c_slow_good: cover property (@(posedge pclk) disable iff (!presetn) $rose(good.slow_good));
   c_slow_osc:  cover property (@(posedge pclk) disable iff (!presetn) $rose(slow_from_osc));
   c_lock_wait: cover property (@(posedge pclk) disable iff (!presetn) $rose(src == tcg_pkg::TCG_SRC_LOCK));
   c_pll_on:    cover property (@(posedge pclk) disable iff (!presetn) $rose(sys_from_pll));
endmodule // tcg_clock_gen

// >>> tcg_divider.sv
`timescale 1ns/1ps
// Programmable divider: one-cycle tick every (ratio+1) enabled cycles
module tcg_divider #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Control
   input  wire logic         in_en,
   input  wire logic [W-1:0] ratio,
   // Output
   output logic              tick
);
   logic [W-1:0] cnt;

   // Count down, reload at zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt  <= '0;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (in_en) begin
            if (cnt == '0) begin
               cnt  <= ratio;
               tick <= 1'b1;
            end else begin
               cnt <= cnt - 1'b1;
            end
         end
      end
   end
endmodule // tcg_divider

// >>> tcg_osc_model.sv
`timescale 1ns/1ps
// Crystal pair: pulses only while enabled, silent when stopped
module tcg_osc_model #(
   parameter int SLOW_GAP = 4
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Enables from the block
   input  wire logic main_en,
   input  wire logic slow_en,
   // Oscillator pulses
   output logic      main_tick,
   output logic      slow_edge
);
   int gap;
   // Main pulses every cycle, slow edges every SLOW_GAP cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap       <= 0;
         main_tick <= 1'b0;
         slow_edge <= 1'b0;
      end else begin
         main_tick <= main_en;
         gap       <= (slow_en && gap < SLOW_GAP - 1) ? gap + 1 : 0;
         slow_edge <= slow_en && gap == SLOW_GAP - 1;
      end
   end
endmodule // tcg_osc_model

// >>> tcg_pkg.sv
package tcg_pkg;
   typedef struct packed {
      logic stop_main;
      logic stop_slow;
   } tcg_pm_req_t;
   typedef struct packed {
      logic main_good;
      logic slow_good;
   } tcg_good_t;
   typedef struct packed {
      logic sys_en;
      logic slow_en;
      logic aux1_en;
      logic aux2_en;
   } tcg_ticks_t;
   typedef enum logic [2:0] {
      TCG_SRC_MAIN = 3'b001,
      TCG_SRC_LOCK = 3'b010,
      TCG_SRC_PLL  = 3'b100
   } tcg_src_t;
endpackage

// >>> triple_clock_generator_tb_top.sv
`timescale 1ns/1ps
`include "tcg_cfg.svh"
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin n_fail++; \
   $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module triple_clock_generator_tb_top;
   typedef struct {int k; logic [11:0] a; logic [31:0] d; int i; logic [31:0] e;} tcg_row_t;
   logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata, rd;
   tcg_pkg::tcg_pm_req_t pm_req;
   tcg_pkg::tcg_good_t   good;
   tcg_pkg::tcg_ticks_t  ticks;
   logic                 mtick, sedge, hf_en, s_en, pll_pd, from_pll, from_osc;
   logic [1:0]           mult;
   wire logic [3:0]      tv = ticks;
   int                   n_fail, n_checks, cyc, n, c1, c2;
   tcg_row_t rows[12] = '{
      '{2, `TCG_OFF_FAST_PRE, 32'h10, 3, 1}, '{2, `TCG_OFF_FAST_PRE, 32'h1F, 3, 16},
      '{2, `TCG_OFF_SLOW_PRE, 32'h3B, 2, 120}, '{2, `TCG_OFF_SLOW_PRE, 32'hFF, 2, 512},
      '{0, `TCG_OFF_SLOW_PRE, 0, 0, 32'hFF},
      '{2, `TCG_OFF_AUX_PRE, 32'h31, 1, 2}, '{2, `TCG_OFF_AUX_PRE, 32'h31, 0, 4},
      '{1, `TCG_OFF_CTRL, 32'h1C, 0, 0}, '{0, `TCG_OFF_CTRL, 0, 0, 32'h1E},
      '{1, 12'h020, 32'hFF, 0, 0}, '{0, 12'h020, 0, 0, 32'h0}, // Unmapped place
      '{0, `TCG_OFF_STATUS, 0, 0, 32'h1}};
   tcg_clock_gen #(.PLL_LOCK(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pm_req(pm_req), .main_osc_tick(mtick), .slow_osc_edge(sedge), .high_freq_oscillator_en(hf_en),
      .slow_osc_en(s_en), .good(good), .pll_power_down(pll_pd), .pll_mult(mult), .ticks(ticks),
      .sys_from_pll(from_pll), .slow_from_osc(from_osc));
   tcg_osc_model i_osc (.pclk(pclk), .presetn(presetn), .main_en(hf_en), .slow_en(s_en),
      .main_tick(mtick), .slow_edge(sedge));
   // Clock and cycle ceiling
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         report_and_stop();
      end
   end
   // One APB transfer, held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Cycles between two pulses of one enable
   task automatic per(input int i, output int p);
      p = 0;
      // Skip pulses still timed by the ratio in force before the write
      repeat (2) @(posedge pclk);
      while (tv[i] !== 1'b1) @(posedge pclk);
      do begin @(posedge pclk); p++; end while (tv[i] !== 1'b1);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      pm_req = '{stop_main: 1'b1, stop_slow: 1'b1};
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      `CHK("main_good_halted", 2'b00, good)
      `CHK("osc_enables_halted", 2'b00, {hf_en, s_en})
      pm_req.stop_main <= 1'b0;
      n = 0;
      do begin @(posedge pclk); n++; end while (good.main_good !== 1'b1);
      `CHK("main_delay_ok", 1'b1, n >= 32760 && n <= 32772)
      $display("test startup done");
      foreach (rows[r]) begin
         apb(rows[r].k != 0, rows[r].a, rows[r].d);
         if (rows[r].k == 0) `CHK("row_read", rows[r].e, rd)
         if (rows[r].k == 2) begin per(rows[r].i, n); `CHK("row_period", rows[r].e, n); end
      end
      $display("test rows done");
      apb(1, `TCG_OFF_CTRL, 32'h1F);
      repeat (3) @(posedge pclk);
      `CHK("slow_src_no_toggle", 1'b0, from_osc)
      pm_req.stop_slow <= 1'b0;
      n = 0;
      do begin @(posedge pclk); n++; end while (good.slow_good !== 1'b1);
      `CHK("slow_delay_ok", 1'b1, n >= 4 * 63 - 8 && n <= 4 * 64 + 8)
      repeat (20) @(posedge pclk);
      `CHK("slow_src_osc", 1'b1, from_osc)
      per(2, n);
      `CHK("slow_osc_period", 4, n)
      apb(0, `TCG_OFF_STATUS, 0);
      `CHK("status", 32'h7, rd)
      `CHK("osc_enables_run", 2'b11, {hf_en, s_en})
      pm_req.stop_slow <= 1'b1;
      @(posedge pclk);
      @(negedge pclk);
      `CHK("slow_good_drop", 1'b0, good.slow_good)
      apb(1, `TCG_OFF_CTRL, 32'h1E);
      $display("test slow done");
      apb(1, `TCG_OFF_FAST_PRE, 32'h20);
      @(negedge pclk);
      `CHK("mult_2", 2'h2, mult)
      apb(1, `TCG_OFF_FAST_PRE, 32'h10);
      @(negedge pclk);
      `CHK("mult_1", 2'h1, mult)
      apb(1, `TCG_OFF_CTRL, 32'h1A);
      @(negedge pclk);
      `CHK("pll_pd_off", 1'b0, pll_pd)
      apb(1, `TCG_OFF_CTRL, 32'h18);
      apb(0, `TCG_OFF_CTRL, 0);
      `CHK("fast_sel_before_lock", 1'b1, rd[1])
      for (c1 = 0; c1 < 10 && rd[1] !== 1'b0; c1++) begin
         apb(1, `TCG_OFF_CTRL, 32'h18);
         apb(0, `TCG_OFF_CTRL, 0);
      end
      `CHK("ctrl_on_pll", 32'h18, rd)
      `CHK("sys_on_pll", 1'b1, from_pll)
      apb(1, `TCG_OFF_CTRL, 32'h1A);
      apb(0, `TCG_OFF_CTRL, 0);
      `CHK("ctrl_back_main", 32'h1A, rd)
      `CHK("sys_on_main", 1'b0, from_pll)
      $display("test pll done");
      apb(1, `TCG_OFF_CTRL, 32'h16);
      // Let the last pulse launched before the write pass
      repeat (2) @(posedge pclk);
      c1 = 0;
      c2 = 0;
      repeat (32) begin @(posedge pclk); c1 += tv[1]; c2 += tv[0]; end
      `CHK("aux1_off", 0, c1)
      `CHK("aux2_on", 8, c2)
      $display("test aux done");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      `CHK("reset_src", 2'b00, {from_pll, from_osc})
      apb(0, `TCG_OFF_CTRL, 0);
      `CHK("ctrl_reset", 32'(`TCG_CTRL_RESET), rd)
      apb(0, `TCG_OFF_FAST_PRE, 0);
      `CHK("fast_pre_reset", 32'(`TCG_FPRE_RESET), rd)
      apb(0, `TCG_OFF_SLOW_PRE, 0);
      `CHK("slow_pre_reset", 32'(`TCG_SPRE_RESET), rd)
      $display("test reset done");
      report_and_stop();
   end
endmodule // triple_clock_generator_tb_top
